/* File: src/charger_status_registers.sv */
// Top of the charger status register pair with read port and change events
`timescale 1ns/1ps
module charger_status_registers
(
    input wire logic clk,
    input wire logic reset,
    input wire logic input_power_good_reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_read,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic vin_floor_raw,
    input wire logic iin_limit_raw,
    input wire logic sys_floor_raw,
    input wire logic die_temp_raw,
    input wire logic thermistor_monitor_on,
    input wire logic [2:0] temp_zone_raw,
    input wire logic [3:0] charger_state_raw,
    input wire logic input_suspend_request,
    input wire logic [1:0] input_state_raw,
    input wire logic charging_raw,
    input wire logic low_cc_current,
    input wire logic supplement_mode,
    output logic input_path_enable,
    output logic safety_timer_paused,
    output logic charger_state_change_flag,
    output logic input_state_change_flag,
    output logic temp_zone_change_flag
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int raw_w = 18;
    logic [raw_w-1:0] raw_in;
    logic [raw_w-1:0] sync1_reg;
    logic [raw_w-1:0] sync2_reg;
    logic pg_sync1_reg;
    logic pg_sync2_reg;

    assign raw_in = {vin_floor_raw, iin_limit_raw, sys_floor_raw, die_temp_raw, thermistor_monitor_on,
        temp_zone_raw, charger_state_raw, input_suspend_request, input_state_raw, charging_raw,
        low_cc_current, supplement_mode};

    // Raw conditions come from analog blocks on no clock; two flops each
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            pg_sync1_reg <= 1'b1;
            pg_sync2_reg <= 1'b1;
        end
        else
        begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            pg_sync1_reg <= input_power_good_reset;
            pg_sync2_reg <= pg_sync1_reg;
        end
    end

    logic s_vin;
    logic s_iin;
    logic s_sys;
    logic s_die;
    logic s_thm_on;
    logic [2:0] s_zone;
    logic [3:0] s_state;
    logic s_susp;
    logic [1:0] s_input;
    logic s_charging;
    logic s_low_cc;
    logic s_supp;
    assign {s_vin, s_iin, s_sys, s_die, s_thm_on, s_zone, s_state, s_susp, s_input, s_charging,
        s_low_cc, s_supp} = sync2_reg;

    // ------------------------------------------------------------
    // Field qualification
    // ------------------------------------------------------------
    logic [2:0] zone_next;
    logic [3:0] state_next;
    logic [1:0] input_next;
    logic paused_next;

    always_comb
    begin
        // Monitor off forces the disabled code; reserved codes are passed as seen
        zone_next = s_thm_on ? s_zone : charger_status_pkg::zone_off;
        state_next = s_state;
        // A suspend request overrides whatever the comparators report
        input_next = s_susp ? charger_status_pkg::in_under_or_suspend : s_input;
        unique case (state_next)
            charger_status_pkg::charger_cc:
                paused_next = s_low_cc || s_supp;
            charger_status_pkg::charger_temp_fault:
                paused_next = 1'b1;
            charger_status_pkg::charger_prequal, charger_status_pkg::charger_jeita_cc,
            charger_status_pkg::charger_cv, charger_status_pkg::charger_jeita_cv,
            charger_status_pkg::charger_topoff, charger_status_pkg::charger_jeita_topoff:
                paused_next = s_supp;
            default:
                // Timers idle in off, done, prequal fault and fast-charge fault states
                paused_next = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------
    logic [7:0] loop_temp_reg;
    logic [7:0] state_input_reg;

    // Writes never reach these flops; power-good reset zeroes them
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            loop_temp_reg <= charger_status_pkg::status_reset_value;
        end
        else if (pg_sync2_reg)
        begin
            loop_temp_reg <= charger_status_pkg::status_reset_value;
        end
        else
        begin
            loop_temp_reg <= 8'h00;
            loop_temp_reg[charger_status_pkg::vin_floor_bit] <= s_vin;
            loop_temp_reg[charger_status_pkg::iin_limit_bit] <= s_iin;
            loop_temp_reg[charger_status_pkg::sys_floor_bit] <= s_sys;
            loop_temp_reg[charger_status_pkg::die_temp_bit] <= s_die;
            loop_temp_reg[charger_status_pkg::temp_zone_lsb +: 3] <= zone_next;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_input_reg <= charger_status_pkg::status_reset_value;
        end
        else if (pg_sync2_reg)
        begin
            state_input_reg <= charger_status_pkg::status_reset_value;
        end
        else
        begin
            state_input_reg[charger_status_pkg::state_code_lsb +: 4] <= state_next;
            state_input_reg[charger_status_pkg::input_state_lsb +: 2] <= input_next;
            state_input_reg[charger_status_pkg::charging_bit] <= s_charging;
            state_input_reg[charger_status_pkg::timer_paused_bit] <= paused_next;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Writes to these offsets are silently dropped
    logic unused_write;
    assign unused_write = reg_write ^ (|reg_wdata);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_read)
        begin
            if (reg_addr == charger_status_pkg::loop_temp_status_addr)
            begin
                reg_rdata <= loop_temp_reg;
            end
            else if (reg_addr == charger_status_pkg::state_input_status_addr)
            begin
                reg_rdata <= state_input_reg;
            end
            else
            begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs and change events
    // ------------------------------------------------------------
    // Path stays open only once the input is debounced and valid
    assign input_path_enable = (state_input_reg[charger_status_pkg::input_state_lsb +: 2] ==
        charger_status_pkg::in_valid);
    assign safety_timer_paused = state_input_reg[charger_status_pkg::timer_paused_bit];

    status_fields_if fields_bus ();
    assign fields_bus.charger_state_code = state_input_reg[charger_status_pkg::state_code_lsb +: 4];
    assign fields_bus.input_supply_state = state_input_reg[charger_status_pkg::input_state_lsb +: 2];
    assign fields_bus.battery_temp_zone = loop_temp_reg[charger_status_pkg::temp_zone_lsb +: 3];

    field_change_detect change_detect
    (
        .clk(clk),
        .reset(reset),
        .power_good_reset(pg_sync2_reg),
        .fields(fields_bus)
    );

    assign charger_state_change_flag = fields_bus.charger_state_change_flag;
    assign input_state_change_flag = fields_bus.input_state_change_flag;
    assign temp_zone_change_flag = fields_bus.temp_zone_change_flag;
endmodule

/* File: src/charger_status_pkg.sv */
// Package of register offsets, field positions and codes for the charger status registers
// What this block does
// - Top bit of the first status register always reads zero.
// - Bit 6 of first register shows the input voltage floor loop engaged.
// - Bit 5 of first register shows the input current limit loop active.
// - Bit 4 of first register shows the system voltage floor loop engaged.
// - Bit 3 of first register shows the die temperature loop cutting current.
// - Three-bit battery temperature zone: off, cold, cool, warm, hot, normal; rest reserved.
// - Four-bit charger state codes 0 to 7 cover off through JEITA top-off.
// - Codes 8, 10, 11, 12 are done and the three faults; higher reserved.
// - Code 9 reports done reached through JEITA-modified fast-charge states.
// - Two-bit input state: undervoltage/suspend, overvoltage, debouncing, valid.
// - No input power is drawn while the input is being debounced.
// - Bit 1 of second register shows charging in progress.
// - Safety timer pauses on low CC current, supplement mode or temperature fault.
// - Bit 0 of second register shows the active timer paused.
// - A change of the charger state field sets the charger state change flag.
// - A change of the input state field sets the input state change flag.
// - A change of the temperature zone field sets the temp zone change flag.
package charger_status_pkg;
    localparam logic [7:0] loop_temp_status_addr = 8'h02;
    localparam logic [7:0] state_input_status_addr = 8'h03;
    localparam logic [7:0] status_reset_value = 8'h00;
    localparam int vin_floor_bit = 6;
    localparam int iin_limit_bit = 5;
    localparam int sys_floor_bit = 4;
    localparam int die_temp_bit = 3;
    localparam int temp_zone_lsb = 0;
    localparam int state_code_lsb = 4;
    localparam int input_state_lsb = 2;
    localparam int charging_bit = 1;
    localparam int timer_paused_bit = 0;
    // Timer pauses below this share of the fast-charge current
    localparam int timer_pause_percent = 20;

    typedef enum logic [2:0]
    {
        zone_off = 3'h0,
        zone_cold = 3'h1,
        zone_cool = 3'h2,
        zone_warm = 3'h3,
        zone_hot = 3'h4,
        zone_normal = 3'h5
    } temp_zone_t;

    typedef enum logic [3:0]
    {
        charger_off = 4'h0,
        charger_prequal = 4'h1,
        charger_cc = 4'h2,
        charger_jeita_cc = 4'h3,
        charger_cv = 4'h4,
        charger_jeita_cv = 4'h5,
        charger_topoff = 4'h6,
        charger_jeita_topoff = 4'h7,
        charger_done = 4'h8,
        charger_jeita_done = 4'h9,
        charger_prequal_fault = 4'ha,
        charger_fast_charge_fault = 4'hb,
        charger_temp_fault = 4'hc
    } charger_state_t;

    typedef enum logic [1:0]
    {
        in_under_or_suspend = 2'h0,
        in_over = 2'h1,
        in_debounce = 2'h2,
        in_valid = 2'h3
    } input_state_t;
endpackage

/* File: src/status_fields_if.sv */
// Interface carrying the live status fields to the change detector
`timescale 1ns/1ps
interface status_fields_if;
    logic [3:0] charger_state_code;
    logic [1:0] input_supply_state;
    logic [2:0] battery_temp_zone;
    logic charger_state_change_flag;
    logic input_state_change_flag;
    logic temp_zone_change_flag;
    modport source
    (
        output charger_state_code,
        output input_supply_state,
        output battery_temp_zone,
        input charger_state_change_flag,
        input input_state_change_flag,
        input temp_zone_change_flag
    );
    modport detector
    (
        input charger_state_code,
        input input_supply_state,
        input battery_temp_zone,
        output charger_state_change_flag,
        output input_state_change_flag,
        output temp_zone_change_flag
    );
endinterface

/* File: src/field_change_detect.sv */
// Change detector: one-cycle pulses when a status field changes value
`timescale 1ns/1ps
module field_change_detect
(
    input wire logic clk,
    input wire logic reset,
    input wire logic power_good_reset,
    status_fields_if.detector fields
);
    logic [3:0] state_prev_reg;
    logic [1:0] input_prev_reg;
    logic [2:0] zone_prev_reg;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_prev_reg <= 4'h0;
            input_prev_reg <= 2'h0;
            zone_prev_reg <= 3'h0;
        end
        else if (power_good_reset)
        begin
            state_prev_reg <= 4'h0;
            input_prev_reg <= 2'h0;
            zone_prev_reg <= 3'h0;
        end
        else
        begin
            state_prev_reg <= fields.charger_state_code;
            input_prev_reg <= fields.input_supply_state;
            zone_prev_reg <= fields.battery_temp_zone;
        end
    end

    // Zeroing under power-good reset is not a change, so no pulse then
    assign fields.charger_state_change_flag = !power_good_reset &&
        (fields.charger_state_code != state_prev_reg);
    assign fields.input_state_change_flag = !power_good_reset &&
        (fields.input_supply_state != input_prev_reg);
    assign fields.temp_zone_change_flag = !power_good_reset &&
        (fields.battery_temp_zone != zone_prev_reg);
endmodule

/* File: tb/charger_status_monitor.sv */
// Checker for the charger status register pair, seen from its ports
`timescale 1ns/1ps
module charger_status_monitor
(
    input wire logic clk,
    input wire logic reset,
    input wire logic input_power_good_reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic vin_floor_raw,
    input wire logic iin_limit_raw,
    input wire logic sys_floor_raw,
    input wire logic die_temp_raw,
    input wire logic thermistor_monitor_on,
    input wire logic [2:0] temp_zone_raw,
    input wire logic [3:0] charger_state_raw,
    input wire logic input_suspend_request,
    input wire logic [1:0] input_state_raw,
    input wire logic charging_raw,
    input wire logic low_cc_current,
    input wire logic supplement_mode,
    input wire logic input_path_enable,
    input wire logic safety_timer_paused,
    input wire logic charger_state_change_flag,
    input wire logic input_state_change_flag,
    input wire logic temp_zone_change_flag
);
    // Fields lag the raw pins by three edges, so checks wait until power-good has been low long enough
    logic [3:0] quiet_cnt;
    logic [2:0] pg_cnt;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            quiet_cnt <= 4'h0;
            pg_cnt <= 3'h0;
        end
        else if (input_power_good_reset)
        begin
            quiet_cnt <= 4'h0;
            pg_cnt <= (pg_cnt == 3'h7) ? 3'h7 : pg_cnt + 3'h1;
        end
        else
        begin
            quiet_cnt <= (quiet_cnt == 4'hf) ? 4'hf : quiet_cnt + 4'h1;
            pg_cnt <= 3'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_loop_bits;
        reg_read && reg_addr == 8'h02 && quiet_cnt > 4'h6 |=> reg_rdata[7:3] == {1'b0, $past(vin_floor_raw, 4),
            $past(iin_limit_raw, 4), $past(sys_floor_raw, 4), $past(die_temp_raw, 4)};
    endproperty
    a_loop_bits: assert property (p_loop_bits)
        else $error("loop status bits wrong");
    property p_zone;
        reg_read && reg_addr == 8'h02 && quiet_cnt > 4'h6 |=>
            reg_rdata[2:0] == ($past(thermistor_monitor_on, 4) ? $past(temp_zone_raw, 4) : 3'h0);
    endproperty
    a_zone: assert property (p_zone) else $error("temperature zone field wrong");
    property p_state;
        reg_read && reg_addr == 8'h03 && quiet_cnt > 4'h6 |=> reg_rdata[7:4] == $past(charger_state_raw, 4);
    endproperty
    a_state: assert property (p_state) else $error("charger state field wrong");
    property p_input;
        reg_read && reg_addr == 8'h03 && quiet_cnt > 4'h6 |=> reg_rdata[3:1] ==
            {($past(input_suspend_request, 4) ? 2'h0 : $past(input_state_raw, 4)), $past(charging_raw, 4)};
    endproperty
    a_input: assert property (p_input) else $error("input state or charging bit wrong");
    property p_path;
        quiet_cnt > 4'h6 |-> input_path_enable ==
            (!$past(input_suspend_request, 3) && $past(input_state_raw, 3) == 2'h3);
    endproperty
    a_path: assert property (p_path) else $error("input path enabled outside valid state");
    property p_paused;
        quiet_cnt > 4'h6 |-> safety_timer_paused == (($past(charger_state_raw, 3) == 4'h2 && $past(low_cc_current, 3))
            || ($past(charger_state_raw, 3) inside {[4'h1:4'h7]} && $past(supplement_mode, 3))
            || $past(charger_state_raw, 3) == 4'hc);
    endproperty
    a_paused: assert property (p_paused) else $error("timer pause bit wrong");
    property p_unmapped;
        reg_read && reg_addr != 8'h02 && reg_addr != 8'h03 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_pg_zero;
        pg_cnt == 3'h7 |-> !input_path_enable && !safety_timer_paused && !charger_state_change_flag;
    endproperty
    a_pg_zero: assert property (p_pg_zero) else $error("fields live during power-good reset");
    property p_state_flag;
        quiet_cnt > 4'h8 |-> charger_state_change_flag == ($past(charger_state_raw, 3) != $past(charger_state_raw, 4));
    endproperty
    a_state_flag: assert property (p_state_flag) else $error("state change flag wrong");
    property p_input_flag;
        quiet_cnt > 4'h8 |-> input_state_change_flag ==
            (($past(input_suspend_request, 3) ? 2'h0 : $past(input_state_raw, 3)) !=
            ($past(input_suspend_request, 4) ? 2'h0 : $past(input_state_raw, 4)));
    endproperty
    a_input_flag: assert property (p_input_flag) else $error("input change flag wrong");
    property p_zone_flag;
        quiet_cnt > 4'h8 |-> temp_zone_change_flag ==
            (($past(thermistor_monitor_on, 3) ? $past(temp_zone_raw, 3) : 3'h0) !=
            ($past(thermistor_monitor_on, 4) ? $past(temp_zone_raw, 4) : 3'h0));
    endproperty
    a_zone_flag: assert property (p_zone_flag) else $error("zone change flag wrong");
    c_flag: cover property (charger_state_change_flag);
    c_read: cover property (reg_read && reg_addr == 8'h03);
    c_pg: cover property (pg_cnt == 3'h7);
endmodule
bind charger_status_registers charger_status_monitor i_mon
(
    .clk(clk),
    .reset(reset),
    .input_power_good_reset(input_power_good_reset),
    .reg_addr(reg_addr),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .vin_floor_raw(vin_floor_raw),
    .iin_limit_raw(iin_limit_raw),
    .sys_floor_raw(sys_floor_raw),
    .die_temp_raw(die_temp_raw),
    .thermistor_monitor_on(thermistor_monitor_on),
    .temp_zone_raw(temp_zone_raw),
    .charger_state_raw(charger_state_raw),
    .input_suspend_request(input_suspend_request),
    .input_state_raw(input_state_raw),
    .charging_raw(charging_raw),
    .low_cc_current(low_cc_current),
    .supplement_mode(supplement_mode),
    .input_path_enable(input_path_enable),
    .safety_timer_paused(safety_timer_paused),
    .charger_state_change_flag(charger_state_change_flag),
    .input_state_change_flag(input_state_change_flag),
    .temp_zone_change_flag(temp_zone_change_flag)
);

/* File: tb/charger_status_registers_test.sv */
// Self-checking bench for the charger status register pair
`timescale 1ns/1ps
module charger_status_registers_test;
    logic clk, reset, input_power_good_reset, reg_read, reg_write, vin_floor_raw, iin_limit_raw, sys_floor_raw;
    logic die_temp_raw, thermistor_monitor_on, input_suspend_request, charging_raw, low_cc_current, supplement_mode;
    logic input_path_enable, safety_timer_paused, charger_state_change_flag, input_state_change_flag;
    logic temp_zone_change_flag;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] temp_zone_raw;
    logic [3:0] charger_state_raw;
    logic [1:0] input_state_raw, fld, prev_fld;
    logic [6:0] tbl [8] = '{7'h15, 7'h24, 7'h46, 7'h23, 7'h61, 7'h42, 7'h02, 7'h1c};
    int err_count, n_checks, n_chg, n_in, n_tz, cycles;

    charger_status_registers i_dut
    (
        .clk(clk), .reset(reset), .input_power_good_reset(input_power_good_reset),
        .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .vin_floor_raw(vin_floor_raw), .iin_limit_raw(iin_limit_raw),
        .sys_floor_raw(sys_floor_raw), .die_temp_raw(die_temp_raw),
        .thermistor_monitor_on(thermistor_monitor_on), .temp_zone_raw(temp_zone_raw),
        .charger_state_raw(charger_state_raw), .input_suspend_request(input_suspend_request),
        .input_state_raw(input_state_raw), .charging_raw(charging_raw),
        .low_cc_current(low_cc_current), .supplement_mode(supplement_mode),
        .input_path_enable(input_path_enable), .safety_timer_paused(safety_timer_paused),
        .charger_state_change_flag(charger_state_change_flag),
        .input_state_change_flag(input_state_change_flag),
        .temp_zone_change_flag(temp_zone_change_flag)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            wrap_up();
        end
    end

    task automatic check(logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Waits past the sync and register delay, counting change pulses on the way
    task automatic settle();
        n_chg = 0;
        n_in = 0;
        n_tz = 0;
        repeat (6)
        begin
            @(posedge clk);
            #1;
            n_chg += (charger_state_change_flag === 1'b1);
            n_in += (input_state_change_flag === 1'b1);
            n_tz += (temp_zone_change_flag === 1'b1);
        end
    endtask

    task automatic read_chk(logic [7:0] addr, logic [7:0] exp);
        @(posedge clk);
        reg_addr <= addr;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic t_write_ignored();
        vin_floor_raw <= 1'b1;
        settle();
        @(posedge clk);
        reg_addr <= 8'h02;
        reg_wdata <= 8'hff;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        read_chk(8'h02, 8'h40);
        read_chk(8'h07, 8'h00);
    endtask

    task automatic t_loops();
        thermistor_monitor_on <= 1'b1;
        temp_zone_raw <= 3'h7;
        for (int i = 0; i < 4; i++)
        begin
            {vin_floor_raw, iin_limit_raw, sys_floor_raw, die_temp_raw} <= 4'h8 >> i;
            settle();
            read_chk(8'h02, (8'h40 >> i) | 8'h07);
        end
        die_temp_raw <= 1'b0;
    endtask

    task automatic t_zones();
        for (int z = 0; z < 8; z++)
        begin
            temp_zone_raw <= z[2:0];
            settle();
            check(8'(n_tz), 8'h01);
            read_chk(8'h02, {5'h0, z[2:0]});
        end
        thermistor_monitor_on <= 1'b0;
        settle();
        read_chk(8'h02, 8'h00);
    endtask

    task automatic t_states();
        for (int s = 1; s < 16; s++)
        begin
            charger_state_raw <= s[3:0];
            settle();
            check(8'(n_chg), 8'h01);
            read_chk(8'h03, {s[3:0], 3'h0, s[3:0] == 4'hc});
        end
    endtask

    task automatic t_input();
        charger_state_raw <= 4'h0;
        prev_fld = 2'h0;
        for (int k = 1; k < 8; k++)
        begin
            {input_suspend_request, input_state_raw} <= k[2:0];
            charging_raw <= k[0];
            fld = k[2] ? 2'h0 : k[1:0];
            settle();
            check(8'(n_in), 8'(fld != prev_fld));
            check({7'h0, input_path_enable}, {7'h0, fld == 2'h3});
            read_chk(8'h03, {4'h0, fld, k[0], 1'b0});
            prev_fld = fld;
        end
    endtask

    task automatic t_timer();
        for (int t = 0; t < 8; t++)
        begin
            {charger_state_raw, low_cc_current, supplement_mode} <= tbl[t][6:1];
            settle();
            check({7'h0, safety_timer_paused}, {7'h0, tbl[t][0]});
        end
    endtask

    task automatic t_power_good();
        {charger_state_raw, low_cc_current, supplement_mode} <= 6'h14;
        vin_floor_raw <= 1'b1;
        settle();
        input_power_good_reset <= 1'b1;
        settle();
        check(8'(n_chg), 8'h00);
        read_chk(8'h02, 8'h00);
        read_chk(8'h03, 8'h00);
        input_power_good_reset <= 1'b0;
        settle();
        check(8'(n_chg), 8'h01);
        read_chk(8'h03, 8'h52);
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        {reset, input_power_good_reset, reg_read, reg_write, reg_addr, reg_wdata} = {3'h4, 17'h0};
        {vin_floor_raw, iin_limit_raw, sys_floor_raw, die_temp_raw, thermistor_monitor_on} = 5'h0;
        {temp_zone_raw, charger_state_raw, input_suspend_request, input_state_raw} = 10'h0;
        {charging_raw, low_cc_current, supplement_mode} = 3'h0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        read_chk(8'h03, 8'h00);
        t_write_ignored();
        t_loops();
        t_zones();
        t_states();
        t_input();
        t_timer();
        t_power_good();
        wrap_up();
    end
endmodule
